// *** timer_channel_mode_control.sv ***
// Function
// - Input capture: active pin edge sets the channel event flag, bit 7.
// - Output compare or edge PWM: counter equal to channel value sets flag.
// - Center PWM: every counter match, up or down, sets the flag.
// - Interrupt request is high while flag and enable are both set.
// - Flag clears only after a read with flag set, then write of 0.
// - A new event between arming read and clearing write cancels the clear.
// - Writing 1 to the flag does nothing; reset clears the flag.
// - Interrupt enable at bit 6 is read/write and cleared by reset.
// - Center off and upper mode bit set selects edge-aligned PWM.
// - Center off, upper bit 0: pattern 00 capture, 01 compare.
// - Edge/level code 0:0 releases the pin in every mode.
// - Capture edges: 01 rising, 10 falling, 11 either.
// - Compare action: 00 none, 01 toggle, 10 low, 11 high.
// - Edge PWM: code 10 high-true pulses, X1 low-true pulses.
// - Center select ignores mode bits; polarity acts on up-counting match.
// - Unstable pin when entering capture may raise a spurious flag.
// - Center select makes the counter count up/down and forces center PWM.
// - An active capture edge copies the counter into the channel value.
// - Any control register write resets the value byte-coherency latch.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module timer_channel_mode_control
  import timer_channel_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire reg_req_s    reg_req,
  output logic [7:0]       reg_rdata,
  input  wire counter_s    counter,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             irq,
  output logic             counter_updown
);

  // ==========================================================
  // State
  typedef struct packed {
    control_s    ctrl;
    logic        clear_armed;
    logic [15:0] chan_value;
    logic [15:0] rd_buf;
    logic        rd_latched;
    logic [7:0]  wr_high;
    logic [7:0]  wr_low;
    logic        wr_high_seen;
    logic        wr_low_seen;
    logic        pin_sync1;
    logic        pin_sync2;
    logic        pin_prev;
    logic        pin_out;
    logic        pin_oe;
    logic        irq;
    logic        updown;
    logic [7:0]  rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  channel_mode_e mode;
  logic          rising;
  logic          falling;
  logic          capture_edge;
  logic          match;
  logic          match_up;
  logic          match_down;
  logic          event_hit;
  logic          sc_write;
  logic          sc_read;
  logic [7:0]    sc_view;
  logic          value_rd;
  logic          value_wr_high;
  logic          value_wr_low;
  logic          soft_compare;
  logic          pin_next;
  logic [7:0]    rdata_next;

  // ==========================================================
  // Mode decode
  always_comb
  begin
    if (state_reg.ctrl.edge_level_select == ELS_OFF)
      mode = MODE_PIN_RELEASED;
    else if (counter.center_pwm_select)
      mode = MODE_CENTER_PWM;
    else if (state_reg.ctrl.mode_select_upper)
      mode = MODE_EDGE_PWM;
    else if (state_reg.ctrl.mode_select_lower)
      mode = MODE_OUTPUT_COMPARE;
    else
      mode = MODE_INPUT_CAPTURE;
  end

  // ==========================================================
  // Event detection
  // Edges come from the second and third stages only; the first stage
  // feeds nothing but the second, so metastability cannot leak.
  assign rising  = state_reg.pin_sync2 & ~state_reg.pin_prev;
  assign falling = ~state_reg.pin_sync2 & state_reg.pin_prev;

  always_comb
  begin
    capture_edge = 1'b0;
    if (mode == MODE_INPUT_CAPTURE)
    begin
      case (state_reg.ctrl.edge_level_select)
        ELS_RISING:  capture_edge = rising;
        ELS_FALLING: capture_edge = falling;
        ELS_BOTH:    capture_edge = rising | falling;
        default:     capture_edge = 1'b0;
      endcase
    end
  end

  // Matches are taken only when the counter steps, so a stalled
  // counter sitting on the value does not flag every cycle.
  assign match      = counter.step && (counter.value == state_reg.chan_value);
  assign match_up   = match & ~counter.down;
  assign match_down = match & counter.down;

  // A released pin still works as a software timer on compare
  assign soft_compare = match & ~state_reg.ctrl.mode_select_upper
                        & state_reg.ctrl.mode_select_lower
                        & ~counter.center_pwm_select;

  always_comb
  begin
    case (mode)
      MODE_INPUT_CAPTURE:  event_hit = capture_edge;
      MODE_OUTPUT_COMPARE: event_hit = match;
      MODE_EDGE_PWM:       event_hit = match;
      MODE_CENTER_PWM:     event_hit = match;
      MODE_PIN_RELEASED:   event_hit = soft_compare;
      default:             event_hit = 1'b0;
    endcase
  end

  assign sc_write = reg_req.wr && (reg_req.addr == ADDR_STATUS_CONTROL);
  assign sc_read  = reg_req.rd && (reg_req.addr == ADDR_STATUS_CONTROL);
  assign sc_view  = {state_reg.ctrl.event_flag,
                     state_reg.ctrl.irq_enable,
                     state_reg.ctrl.mode_select_upper,
                     state_reg.ctrl.mode_select_lower,
                     state_reg.ctrl.edge_level_select,
                     2'h0};

  // Value byte accesses; the read latch only works in capture mode
  assign value_rd      = reg_req.rd && (mode == MODE_INPUT_CAPTURE) &&
                         (reg_req.addr == ADDR_VALUE_HIGH ||
                          reg_req.addr == ADDR_VALUE_LOW);
  assign value_wr_high = reg_req.wr && (reg_req.addr == ADDR_VALUE_HIGH);
  assign value_wr_low  = reg_req.wr && (reg_req.addr == ADDR_VALUE_LOW);

  // ==========================================================
  // Pin action
  // Kept apart from the state update so the polarity decode reads
  // as one table per mode.
  always_comb
  begin
    pin_next = state_reg.pin_out;
    case (mode)
      MODE_OUTPUT_COMPARE:
      begin
        if (match)
        begin
          case (state_reg.ctrl.edge_level_select)
            ELS_TOGGLE: pin_next = ~state_reg.pin_out;
            ELS_CLEAR:  pin_next = 1'b0;
            ELS_SET:    pin_next = 1'b1;
            default:    pin_next = state_reg.pin_out;
          endcase
        end
      end
      MODE_EDGE_PWM:
      begin
        // Period start drives the active level, the match ends it;
        // the match is checked last so a zero value gives 0% duty.
        if (counter.wrap)
          pin_next = (state_reg.ctrl.edge_level_select == ELS_CLEAR);
        if (match)
          pin_next = (state_reg.ctrl.edge_level_select != ELS_CLEAR);
      end
      MODE_CENTER_PWM:
      begin
        if (match_up)
          pin_next = (state_reg.ctrl.edge_level_select != ELS_CLEAR);
        if (match_down)
          pin_next = (state_reg.ctrl.edge_level_select == ELS_CLEAR);
      end
      default:
        pin_next = state_reg.pin_out;
    endcase
  end

  // ==========================================================
  // Read data
  // Value bytes come from the coherency buffer while it is latched,
  // so a 16-bit read in two halves never mixes two captures.
  always_comb
  begin
    rdata_next = READ_ZERO;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        ADDR_STATUS_CONTROL:
          rdata_next = sc_view;
        ADDR_VALUE_HIGH:
        begin
          if (state_reg.rd_latched)
            rdata_next = state_reg.rd_buf[15:8];
          else
            rdata_next = state_reg.chan_value[15:8];
        end
        ADDR_VALUE_LOW:
        begin
          if (state_reg.rd_latched)
            rdata_next = state_reg.rd_buf[7:0];
          else
            rdata_next = state_reg.chan_value[7:0];
        end
        default:
          rdata_next = READ_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next = state_reg;

    // Pin synchroniser
    state_next.pin_sync1 = pin_in;
    state_next.pin_sync2 = state_reg.pin_sync1;
    state_next.pin_prev  = state_reg.pin_sync2;

    // ------------------------------------------------------
    // Control register writes
    if (sc_write)
    begin
      state_next.ctrl.irq_enable        = reg_req.wdata[BIT_IRQ_ENABLE];
      state_next.ctrl.mode_select_upper = reg_req.wdata[BIT_MODE_UPPER];
      state_next.ctrl.mode_select_lower = reg_req.wdata[BIT_MODE_LOWER];
      state_next.ctrl.edge_level_select = reg_req.wdata[BIT_ELS_HIGH:BIT_ELS_LOW];
      state_next.rd_latched   = 1'b0;
      state_next.wr_high_seen = 1'b0;
      state_next.wr_low_seen  = 1'b0;
      state_next.clear_armed  = 1'b0;
      // A written 1 is simply not a clear request
      if (state_reg.clear_armed && !reg_req.wdata[BIT_EVENT_FLAG])
        state_next.ctrl.event_flag = 1'b0;
    end

    // Arming read; value byte accesses leave the arm alone, only a
    // control write or a new event drops it
    if (sc_read && state_reg.ctrl.event_flag)
      state_next.clear_armed = 1'b1;

    // ------------------------------------------------------
    // Channel value: coherent reads in capture mode
    if (value_rd)
    begin
      if (!state_reg.rd_latched)
      begin
        state_next.rd_buf     = state_reg.chan_value;
        state_next.rd_latched = 1'b1;
      end
      else
        state_next.rd_latched = 1'b0;
    end

    // Channel value: coherent writes outside capture mode
    if (value_wr_high)
    begin
      state_next.wr_high      = reg_req.wdata;
      state_next.wr_high_seen = 1'b1;
    end
    if (value_wr_low)
    begin
      state_next.wr_low      = reg_req.wdata;
      state_next.wr_low_seen = 1'b1;
    end
    if (state_next.wr_high_seen && state_next.wr_low_seen)
    begin
      if (mode != MODE_INPUT_CAPTURE)
        state_next.chan_value = {state_next.wr_high, state_next.wr_low};
      state_next.wr_high_seen = 1'b0;
      state_next.wr_low_seen  = 1'b0;
    end

    // Capture overrides a coincident software transfer
    if (capture_edge)
      state_next.chan_value = counter.value;

    // ------------------------------------------------------
    // Event flag: a set wins over a clear in the same cycle
    if (event_hit)
    begin
      state_next.ctrl.event_flag = 1'b1;
      state_next.clear_armed     = 1'b0;
    end

    // ------------------------------------------------------
    // Pin drive
    state_next.pin_oe = (mode != MODE_PIN_RELEASED) &&
                        (mode != MODE_INPUT_CAPTURE);
    state_next.pin_out = pin_next;

    // ------------------------------------------------------
    // Outputs
    state_next.irq    = state_next.ctrl.event_flag & state_next.ctrl.irq_enable;
    state_next.updown = counter.center_pwm_select;

    state_next.rdata = rdata_next;
  end

  // ==========================================================
  // Register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg              <= '0;
      state_reg.ctrl         <= control_s'(STATUS_CONTROL_RESET[7:2]);
      state_reg.chan_value   <= CHANNEL_VALUE_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign reg_rdata      = state_reg.rdata;
  assign pin_out        = state_reg.pin_out;
  assign pin_oe         = state_reg.pin_oe;
  assign irq            = state_reg.irq;
  assign counter_updown = state_reg.updown;

endmodule : timer_channel_mode_control

// *** timer_channel_pkg.sv ***
package timer_channel_pkg;

  // ==========================================================
  // Register map (word index on the register port)
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_VALUE_HIGH     = 2'h1;
  localparam logic [1:0] ADDR_VALUE_LOW      = 2'h2;

  // ==========================================================
  // Status and control field positions
  localparam int BIT_EVENT_FLAG  = 7;
  localparam int BIT_IRQ_ENABLE  = 6;
  localparam int BIT_MODE_UPPER  = 5;
  localparam int BIT_MODE_LOWER  = 4;
  localparam int BIT_ELS_HIGH    = 3;
  localparam int BIT_ELS_LOW     = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  STATUS_CONTROL_RESET = 8'h00;
  localparam logic [15:0] CHANNEL_VALUE_RESET  = 16'h0000;
  localparam logic [7:0]  READ_ZERO            = 8'h00;

  // ==========================================================
  // Edge/level select codes
  localparam logic [1:0] ELS_OFF     = 2'h0;
  localparam logic [1:0] ELS_RISING  = 2'h1;
  localparam logic [1:0] ELS_FALLING = 2'h2;
  localparam logic [1:0] ELS_BOTH    = 2'h3;
  localparam logic [1:0] ELS_TOGGLE  = 2'h1;
  localparam logic [1:0] ELS_CLEAR   = 2'h2;
  localparam logic [1:0] ELS_SET     = 2'h3;

  typedef enum logic [2:0] {
    MODE_PIN_RELEASED,
    MODE_INPUT_CAPTURE,
    MODE_OUTPUT_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } channel_mode_e;

  typedef struct packed {
    logic       event_flag;
    logic       irq_enable;
    logic       mode_select_upper;
    logic       mode_select_lower;
    logic [1:0] edge_level_select;
  } control_s;

  // Software register port
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  // Shared counter view from the timer core
  typedef struct packed {
    logic [15:0] value;
    logic        step;
    logic        wrap;
    logic        down;
    logic        center_pwm_select;
  } counter_s;

endpackage : timer_channel_pkg

// *** timer_channel_mode_control_props.sv ***
`timescale 1ns/1ps
// ==========
// Port checker
module timer_channel_mode_control_props
  import timer_channel_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire reg_req_s   reg_req,
  input wire logic [7:0] reg_rdata,
  input wire counter_s   counter,
  input wire logic       pin_in,
  input wire logic       pin_out,
  input wire logic       pin_oe,
  input wire logic       irq,
  input wire logic       counter_updown
);
  logic [4:0] ctrl_reg;
  logic       cen;
  logic       rd_ctrl;
  assign cen = counter.center_pwm_select;
  assign rd_ctrl = reg_req.rd && reg_req.addr == ADDR_STATUS_CONTROL;
  // Software-owned bits 6:2 never change by events
  always_ff @(posedge clk)
    if (!rst_b)
      ctrl_reg <= 5'h00;
    else if (reg_req.wr && reg_req.addr == ADDR_STATUS_CONTROL)
      ctrl_reg <= reg_req.wdata[6:2];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ctrl_read;
    $past(rd_ctrl) |-> reg_rdata[6:0] == {$past(ctrl_reg), 2'b00};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl readback");
  property p_irq_level;
    $past(rd_ctrl) |-> $past(irq) == (reg_rdata[7] & reg_rdata[6]);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level");
  property p_irq_masked;
    !ctrl_reg[4] && !$past(ctrl_reg[4]) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq masked");
  property p_released;
    ctrl_reg[1:0] == ELS_OFF && $past(ctrl_reg[1:0]) == ELS_OFF |-> !pin_oe;
  endproperty
  a_released: assert property (p_released) else $error("pin not released");
  property p_capture;
    !cen && !$past(cen) && ctrl_reg[3:2] == 2'h0 && $past(ctrl_reg[3:2]) == 2'h0 |-> !pin_oe;
  endproperty
  a_capture: assert property (p_capture) else $error("capture drives pin");
  property p_edge_drive;
    !cen && !$past(cen) && ctrl_reg[3] && $past(ctrl_reg[3]) && ctrl_reg[1:0] != 2'h0
      && $past(ctrl_reg[1:0]) != 2'h0 |-> pin_oe;
  endproperty
  a_edge_drive: assert property (p_edge_drive) else $error("edge pwm idle");
  property p_center_drive;
    cen && $past(cen) && ctrl_reg[1:0] != 2'h0 && $past(ctrl_reg[1:0]) != 2'h0 |-> pin_oe;
  endproperty
  a_center_drive: assert property (p_center_drive) else $error("center idle");
  property p_updown;
    $past(cen) |-> counter_updown;
  endproperty
  a_updown: assert property (p_updown) else $error("updown");
endmodule : timer_channel_mode_control_props

bind timer_channel_mode_control timer_channel_mode_control_props u_props (
  .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .counter(counter),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
  .counter_updown(counter_updown));

// *** ext_pin_source.sv ***
`timescale 1ns/1ps
// ==========
// Far-side signal source on the channel pin
module ext_pin_source (
  input  wire logic level,
  input  wire logic slow,
  output logic      pin
);
  // Skew keeps edges away from the clock, like a real asynchronous source
  initial pin = 1'b0;
  always @(level) pin <= #(slow ? 80.3 : 7.3) level;
endmodule : ext_pin_source

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  import timer_channel_pkg::*;
  logic        clk, rst_b, pin_in, pin_out, pin_oe, irq, counter_updown, level, slow, p;
  reg_req_s    reg_req;
  counter_s    counter;
  logic [7:0]  reg_rdata, d;
  logic [15:0] v;
  int          n_fail, n_checks, cyc;
  timer_channel_mode_control u_timer_channel_mode_control (.clk(clk), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .counter(counter), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .counter_updown(counter_updown));
  ext_pin_source u_ext_pin_source (.level(level), .slow(slow), .pin(pin_in));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  // ==========
  // Bus and stimulus tasks
  task wr(input logic [1:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task clr;
    rd(ADDR_STATUS_CONTROL);
    wr(ADDR_STATUS_CONTROL, d & 8'h7f);
  endtask : clr
  task tick(input logic [15:0] val, input logic w, input logic dn);
    @(posedge clk);
    counter <= '{value: val, step: 1'b1, wrap: w, down: dn,
                 center_pwm_select: counter.center_pwm_select};
    @(posedge clk);
    counter.step <= 1'b0;
    counter.wrap <= 1'b0;
    #1;
  endtask : tick
  task settle;
    repeat (8) @(posedge clk);
    #1;
  endtask : settle
  function automatic logic cmp_out(input logic [1:0] c, input logic q);
    case (c)
      ELS_TOGGLE: return ~q;
      ELS_CLEAR:  return 1'b0;
      ELS_SET:    return 1'b1;
      default:    return q;
    endcase
  endfunction : cmp_out
  task wrap_up;
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // ==========
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    reg_req = '0;
    counter = '0;
    level = 1'b0;
    slow = 1'b0;
    void'($urandom(32'hc4b914f2));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_STATUS_CONTROL);
    `CHK(d, STATUS_CONTROL_RESET)
    rd(2'h3);
    `CHK(d, READ_ZERO)
    repeat (8)
    begin
      v = 16'($urandom);
      wr(ADDR_STATUS_CONTROL, v[7:0] | 8'h80);
      rd(ADDR_STATUS_CONTROL);
      `CHK(d, {1'b0, v[6:2], 2'b00})
    end
    for (int e = 1; e < 4; e++)
      for (int r = 0; r < 2; r++)
      begin
        v = 16'($urandom);
        counter.value <= v;
        slow = (r == 1);
        wr(ADDR_STATUS_CONTROL, {4'h4, e[1:0], 2'b00});
        clr();
        level = (r == 0);
        settle();
        rd(ADDR_STATUS_CONTROL);
        `CHK(d[7], e[r])
        `CHK(irq, e[r])
        if (e[r])
        begin
          rd(ADDR_VALUE_HIGH);
          `CHK(d, v[15:8])
          rd(ADDR_VALUE_LOW);
          `CHK(d, v[7:0])
        end
      end
    // Unarmed write, then an event between arming read and clearing write;
    // the control writes also drop a half-done value read
    wr(ADDR_STATUS_CONTROL, 8'h4c);
    rd(ADDR_VALUE_HIGH);
    v = ~v;
    counter.value <= v;
    level = 1'b1;
    settle();
    wr(ADDR_STATUS_CONTROL, 8'h4c);
    rd(ADDR_VALUE_LOW);
    `CHK(d, v[7:0])
    rd(ADDR_STATUS_CONTROL);
    `CHK(d[7], 1'b1)
    level = 1'b0;
    settle();
    wr(ADDR_STATUS_CONTROL, 8'h4c);
    rd(ADDR_STATUS_CONTROL);
    `CHK(d[7], 1'b1)
    wr(ADDR_STATUS_CONTROL, 8'h4c);
    rd(ADDR_STATUS_CONTROL);
    `CHK(d[7], 1'b0)
    `CHK(irq, 1'b0)
    wr(ADDR_STATUS_CONTROL, 8'h10);
    v = 16'($urandom);
    wr(ADDR_VALUE_HIGH, v[15:8]);
    wr(ADDR_VALUE_LOW, v[7:0]);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_STATUS_CONTROL, {4'h1, c[1:0], 2'b00});
      clr();
      tick(~v, 1'b0, 1'b0);
      rd(ADDR_STATUS_CONTROL);
      `CHK(d[7], 1'b0)
      p = pin_out;
      tick(v, 1'b0, 1'b0);
      `CHK(pin_out, cmp_out(c[1:0], p))
      rd(ADDR_STATUS_CONTROL);
      `CHK(d[7], 1'b1)
    end
    for (int c = 1; c < 4; c++)
    begin
      wr(ADDR_STATUS_CONTROL, {3'h1, 1'($urandom), c[1:0], 2'b00});
      tick(~v, 1'b1, 1'b0);
      `CHK(pin_out, c[1:0] == ELS_CLEAR)
      tick(v, 1'b0, 1'b0);
      `CHK(pin_out, c[1:0] != ELS_CLEAR)
    end
    counter.center_pwm_select <= 1'b1;
    for (int c = 1; c < 4; c++)
    begin
      wr(ADDR_STATUS_CONTROL, {2'h0, 2'($urandom), c[1:0], 2'b00});
      tick(v, 1'b0, 1'b0);
      `CHK(pin_out, c[1:0] != ELS_CLEAR)
      clr();
      tick(v, 1'b0, 1'b1);
      `CHK(pin_out, c[1:0] == ELS_CLEAR)
      rd(ADDR_STATUS_CONTROL);
      `CHK(d[7], 1'b1)
      `CHK(counter_updown, 1'b1)
    end
    wrap_up();
  end
endmodule : tb_top
